// >>> rtl/nbd_pkg.sv
// package: opcodes, constants and state types of the alu/branch decoder
package nbd_pkg;

  localparam int NBD_PC_W = 11;
  localparam int NBD_STACK_D = 4;
  localparam int NBD_SP_W = 2;

  // opcodes; the last two open two-byte forms
  localparam logic [7:0] NBD_OP_ADD_CARRY_SKIP = 8'h30;
  localparam logic [7:0] NBD_OP_ADD_MEM = 8'h31;
  localparam logic [7:0] NBD_OP_ADD_DECIMAL_TEN = 8'h4A;
  localparam logic [7:0] NBD_OP_COMPL_ADD_CARRY_SKIP = 8'h10;
  localparam logic [7:0] NBD_OP_CLEAR_ACCUMULATOR = 8'h00;
  localparam logic [7:0] NBD_OP_COMPLEMENT = 8'h40;
  localparam logic [7:0] NBD_OP_NO_OPERATION = 8'h44;
  localparam logic [7:0] NBD_OP_CLEAR_CARRY_FLAG = 8'h32;
  localparam logic [7:0] NBD_OP_SET_CARRY_FLAG = 8'h22;
  localparam logic [7:0] NBD_OP_XOR_MEM = 8'h02;
  localparam logic [7:0] NBD_OP_JUMP_INDIRECT = 8'hFF;
  localparam logic [7:0] NBD_OP_RETURN_PLAIN = 8'h48;
  localparam logic [7:0] NBD_OP_RETURN_THEN_SKIP = 8'h49;
  localparam logic [7:0] NBD_OP_PREFIX = 8'h33;
  localparam logic [7:0] NBD_OP_DIRECT_MEM = 8'h23;

  // high-nibble groups
  localparam logic [3:0] NBD_HI_ADD_IMM_SKIP = 4'h5;
  localparam logic [3:0] NBD_HI_LONG = 4'h6;

  // second bytes after the prefix
  localparam logic [7:0] NBD_OP2_OR_MEM = 8'h1A;
  localparam logic [7:0] NBD_OP2_COPY_ACC_MEM_TO_LATCH = 8'h3C;

  localparam logic [3:0] NBD_DECIMAL_TEN = 4'hA;
  localparam logic [3:0] NBD_PAGE_PAIR_2_3 = 4'h1;
  localparam logic [4:0] NBD_SUB_PAGE = 5'h02;
  localparam logic [NBD_PC_W-1:0] NBD_PC_RESET = 11'h000;

  typedef enum logic [2:0] {
    NBD_PH_FETCH,
    NBD_PH_SECOND,
    NBD_PH_SKIP2,
    NBD_PH_INDIRECT,
    NBD_PH_LATCH_FIX
  } nbd_phase_t;

  // instruction handed to the memory, register and i/o groups elsewhere
  typedef struct packed {
    logic two_byte;
    logic [7:0] first;
    logic [7:0] second;
  } nbd_ext_op_t;

  typedef struct packed {
    nbd_phase_t phase;
    logic [NBD_PC_W-1:0] pc;
    logic [3:0] acc;
    logic carry;
    logic skip;
    logic [NBD_SP_W-1:0] sp;
    logic [NBD_STACK_D-1:0][NBD_PC_W-1:0] stack;
    logic [7:0] op1;
    logic [3:0] jid_mem;
    logic [7:0] latch;
    logic [7:0] latch_hold;
    logic ext_valid;
    nbd_ext_op_t ext;
  } nbd_state_t;

endpackage

// >>> rtl/nbd_core.sv
// alu and transfer-of-control decode/execute for the 4-bit controller
// Contract
// - opcode 30: acc+carry+mem into acc, carry-out to carry, skip on carry
// - opcode 31: acc+mem into acc, carry untouched, no skip
// - opcode 4A: add ten to acc, keep four bits, no skip
// - opcodes 5y: acc+y, skip on carry only if y nonzero, carry kept
// - opcode 10: ~acc+mem+carry into acc, carry-out to carry, skip on carry
// - opcode 00 clears the accumulator, no skip
// - opcode 40 inverts the accumulator, no skip
// - opcode 44 changes nothing except advancing the program counter
// - bytes 33 then 1A OR the memory nibble into acc, no skip
// - opcode 32 clears carry, 22 sets carry, acc untouched, no skip
// - opcode 02 XORs memory nibble into accumulator, no skip
// - opcode FF loads pc low byte from rom at pc-high, acc, mem
// - long jump 6x loads the whole program counter, no skip
// - subroutine-page call pushes pc+1, bumps sp, pc = 00010 and operand
// - long call pushes pc+1 at sp, bumps sp, loads full target
// - opcode 48 decrements sp and reloads pc from that stack entry
// - opcode 49 returns like 48 then always skips the next instruction
// - latch copy may briefly hold 3C before the intended value
`timescale 1ns/1ns
`default_nettype none

module nbd_core
  import nbd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] rom_data_i,
  input wire logic [3:0] ram_nibble_i,
  output logic [NBD_PC_W-1:0] rom_addr_o,
  output logic [NBD_PC_W-1:0] pc_o,
  output logic [3:0] acc_o,
  output logic carry_o,
  output logic skip_o,
  output logic [NBD_SP_W-1:0] sp_o,
  output logic [7:0] latch_o,
  output logic ext_valid_o,
  output nbd_ext_op_t ext_op_o
);

  nbd_state_t state_reg;
  nbd_state_t state_next;

  // four-bit adder with carry-out in bit 4
  function automatic logic [4:0] add4(
    input logic [3:0] a,
    input logic [3:0] b,
    input logic cin
  );
    add4 = {1'b0, a} + {1'b0, b} + {4'h0, cin};
  endfunction

  // bytes that are followed by an operand or selector byte
  function automatic logic two_byte(input logic [7:0] op);
    two_byte = (op == NBD_OP_PREFIX) || (op == NBD_OP_DIRECT_MEM) ||
               (op[7:4] == NBD_HI_LONG);
  endfunction

  // stack pointer after a push; four entries, so it wraps silently
  function automatic logic [NBD_SP_W-1:0] sp_after_push(
    input logic [NBD_SP_W-1:0] sp
  );
    sp_after_push = sp + 2'h1;
  endfunction

  logic [NBD_PC_W-1:0] pc_inc;
  logic [NBD_SP_W-1:0] sp_dec;
  logic [4:0] sum;

  assign pc_inc = state_reg.pc + 11'h001;
  assign sp_dec = state_reg.sp - 2'h1;

  // next-state logic; one rom byte is consumed per clock, except in the latch-fix cycle, which reads none
  always_comb
  begin
    state_next = state_reg;
    state_next.ext_valid = 1'b0;
    sum = 5'h00;
    case (state_reg.phase)
      NBD_PH_FETCH:
      begin
        state_next.pc = pc_inc;
        if (state_reg.skip)
        begin
          // fetched, not executed; a two-byte one also drops its tail
          state_next.skip = 1'b0;
          if (two_byte(rom_data_i))
          begin
            state_next.phase = NBD_PH_SKIP2;
          end
        end
        else if (rom_data_i == NBD_OP_ADD_CARRY_SKIP)
        begin
          // carry in from the flag, carry out both stored and tested
          sum = add4(state_reg.acc, ram_nibble_i, state_reg.carry);
          state_next.acc = sum[3:0];
          state_next.carry = sum[4];
          state_next.skip = sum[4];
        end
        else if (rom_data_i == NBD_OP_ADD_MEM)
        begin
          // plain add; the carry out is dropped on purpose
          sum = add4(state_reg.acc, ram_nibble_i, 1'b0);
          state_next.acc = sum[3:0];
        end
        else if (rom_data_i == NBD_OP_ADD_DECIMAL_TEN)
        begin
          // decimal adjust helper: the carry out is thrown away
          sum = add4(state_reg.acc, NBD_DECIMAL_TEN, 1'b0);
          state_next.acc = sum[3:0];
        end
        else if (rom_data_i[7:4] == NBD_HI_ADD_IMM_SKIP)
        begin
          // the carry flag is deliberately left alone here
          sum = add4(state_reg.acc, rom_data_i[3:0], 1'b0);
          state_next.acc = sum[3:0];
          state_next.skip = sum[4] && (rom_data_i[3:0] != 4'h0);
        end
        else if (rom_data_i == NBD_OP_COMPL_ADD_CARRY_SKIP)
        begin
          // inverted acc turns this into a subtract with borrow
          sum = add4(~state_reg.acc, ram_nibble_i, state_reg.carry);
          state_next.acc = sum[3:0];
          state_next.carry = sum[4];
          state_next.skip = sum[4];
        end
        else if (rom_data_i == NBD_OP_CLEAR_ACCUMULATOR)
        begin
          state_next.acc = 4'h0;
        end
        else if (rom_data_i == NBD_OP_COMPLEMENT)
        begin
          state_next.acc = ~state_reg.acc;
        end
        else if (rom_data_i == NBD_OP_NO_OPERATION)
        begin
          // only the counter moves
          state_next.pc = pc_inc;
        end
        else if (rom_data_i == NBD_OP_CLEAR_CARRY_FLAG)
        begin
          state_next.carry = 1'b0;
        end
        else if (rom_data_i == NBD_OP_SET_CARRY_FLAG)
        begin
          state_next.carry = 1'b1;
        end
        else if (rom_data_i == NBD_OP_XOR_MEM)
        begin
          state_next.acc = state_reg.acc ^ ram_nibble_i;
        end
        else if (rom_data_i == NBD_OP_JUMP_INDIRECT)
        begin
          // pc held so the table lookup uses this instruction's page
          state_next.pc = state_reg.pc;
          state_next.jid_mem = ram_nibble_i;
          state_next.phase = NBD_PH_INDIRECT;
        end
        else if (rom_data_i == NBD_OP_RETURN_PLAIN)
        begin
          // pop: the pointer steps back before the entry is read
          state_next.sp = sp_dec;
          state_next.pc = state_reg.stack[sp_dec];
        end
        else if (rom_data_i == NBD_OP_RETURN_THEN_SKIP)
        begin
          // same pop, then the first instruction after the return is dropped
          state_next.sp = sp_dec;
          state_next.pc = state_reg.stack[sp_dec];
          state_next.skip = 1'b1;
        end
        else if (two_byte(rom_data_i))
        begin
          // prefix and long forms wait for their second byte
          state_next.op1 = rom_data_i;
          state_next.phase = NBD_PH_SECOND;
        end
        else if (rom_data_i[7])
        begin
          // single-byte jumps and page calls; the page is this byte's own
          if (state_reg.pc[10:7] == NBD_PAGE_PAIR_2_3)
          begin
            state_next.pc = {state_reg.pc[10:7], rom_data_i[6:0]};
          end
          else if (rom_data_i[6])
          begin
            state_next.pc = {state_reg.pc[10:6], rom_data_i[5:0]};
          end
          else
          begin
            // a fifth nested call overwrites the oldest entry
            state_next.stack[state_reg.sp] = pc_inc;
            state_next.sp = sp_after_push(state_reg.sp);
            state_next.pc = {NBD_SUB_PAGE, rom_data_i[5:0]};
          end
        end
        else
        begin
          // memory, register and i/o groups are executed elsewhere
          state_next.ext_valid = 1'b1;
          state_next.ext = '{two_byte: 1'b0, first: rom_data_i, second: 8'h00};
        end
      end

      NBD_PH_SECOND:
      begin
        state_next.pc = pc_inc;
        state_next.phase = NBD_PH_FETCH;
        // second byte: selector after the prefix, or operand of a long form
        if (state_reg.op1 == NBD_OP_PREFIX && rom_data_i == NBD_OP2_OR_MEM)
        begin
          state_next.acc = state_reg.acc | ram_nibble_i;
        end
        else if (state_reg.op1 == NBD_OP_PREFIX &&
                 rom_data_i == NBD_OP2_COPY_ACC_MEM_TO_LATCH)
        begin
          // the selector byte lands in the latch for one cycle first;
          // kept on purpose so the lines behave as the real part does
          state_next.latch = rom_data_i;
          state_next.latch_hold = {state_reg.acc, ram_nibble_i};
          state_next.phase = NBD_PH_LATCH_FIX;
        end
        else if (state_reg.op1[7:4] == NBD_HI_LONG)
        begin
          // bit 3 of the first byte tells a call from a plain jump
          if (state_reg.op1[3])
          begin
            // pc already points past the first byte, so pc+1 is the return
            state_next.stack[state_reg.sp] = pc_inc;
            state_next.sp = sp_after_push(state_reg.sp);
          end
          state_next.pc = {state_reg.op1[2:0], rom_data_i};
        end
        else
        begin
          // other prefixed and direct-memory forms are executed elsewhere
          state_next.ext_valid = 1'b1;
          state_next.ext = '{two_byte: 1'b1, first: state_reg.op1, second: rom_data_i};
        end
      end

      NBD_PH_SKIP2:
      begin
        // tail byte of a skipped instruction: only the pc moves
        state_next.pc = pc_inc;
        state_next.phase = NBD_PH_FETCH;
      end

      NBD_PH_INDIRECT:
      begin
        // table byte replaces the low eight bits; the page bits stay
        state_next.pc = {state_reg.pc[10:8], rom_data_i};
        state_next.phase = NBD_PH_FETCH;
      end

      NBD_PH_LATCH_FIX:
      begin
        // rom byte ignored and pc held while the intended value lands
        state_next.latch = state_reg.latch_hold;
        state_next.phase = NBD_PH_FETCH;
      end

      default:
      begin
        // unused phase codes fall back to fetching
        state_next.phase = NBD_PH_FETCH;
      end
    endcase
  end

  // state register; the stack holds no defined value after reset
  // on the real part, but cleared flops cost little and aid debug
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= '0;
      state_reg.pc <= NBD_PC_RESET;
      state_reg.phase <= NBD_PH_FETCH;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // indirect lookup addresses rom by page bits, acc and memory nibble
  assign rom_addr_o = (state_reg.phase == NBD_PH_INDIRECT) ?
                      {state_reg.pc[10:8], state_reg.acc, state_reg.jid_mem} :
                      state_reg.pc;
  assign pc_o = state_reg.pc;
  assign acc_o = state_reg.acc;
  assign carry_o = state_reg.carry;
  assign skip_o = state_reg.skip;
  assign sp_o = state_reg.sp;
  assign latch_o = state_reg.latch;
  assign ext_valid_o = state_reg.ext_valid;
  assign ext_op_o = state_reg.ext;

endmodule

`default_nettype wire

// >>> sim/nbd_core_monitor.sv
// checker: port-level properties of the alu/branch decoder
`timescale 1ns/1ns
`default_nettype none
module nbd_core_monitor
  import nbd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] rom_data_i,
  input wire logic [3:0] ram_nibble_i,
  input wire logic [NBD_PC_W-1:0] pc_o,
  input wire logic [3:0] acc_o,
  input wire logic carry_o,
  input wire logic skip_o,
  input wire logic [NBD_SP_W-1:0] sp_o,
  input wire logic [7:0] latch_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  logic wait_reg;
  logic fix_reg;
  logic run;
  logic [7:0] op;
  assign op = rom_data_i;
  assign run = !wait_reg && !skip_o;
  // operand cycles are not fetches; a kept 33 3c pair adds one more
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wait_reg <= 1'b0;
      fix_reg <= 1'b0;
    end
    else
    begin
      wait_reg <= wait_reg ? fix_reg && op == 8'h3C
        : op == 8'h33 || op == 8'h23 || op[7:4] == 4'h6 || (op == 8'hFF && !skip_o);
      fix_reg <= run && op == 8'h33;
    end
  end
  sequence s_glitch;
    latch_o == 8'h3C ##1 latch_o == {$past(acc_o, 2), $past(ram_nibble_i, 2)};
  endsequence
  property p_clear;
    run && op == 8'h00 |=> acc_o == 4'h0 && !skip_o;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");
  property p_invert;
    run && op == 8'h40 |=> acc_o == ~$past(acc_o) && !skip_o;
  endproperty
  a_invert: assert property (p_invert) else $error("invert failed");
  property p_idle;
    run && op == 8'h44 |=> $stable(acc_o) && $stable(carry_o) && pc_o == $past(pc_o) + 11'h1;
  endproperty
  a_idle: assert property (p_idle) else $error("idle changed state");
  property p_carry_ops;
    run && (op == 8'h32 || op == 8'h22) |=> carry_o == !$past(op[4]) && $stable(acc_o);
  endproperty
  a_carry_ops: assert property (p_carry_ops) else $error("carry op failed");
  property p_imm_zero;
    run && op == 8'h50 |=> !skip_o && $stable(acc_o) && $stable(carry_o);
  endproperty
  a_imm_zero: assert property (p_imm_zero) else $error("zero imm failed");
  property p_ret;
    run && op[7:1] == 7'h24 |=> sp_o == $past(sp_o) - 2'h1 && skip_o == $past(op[0]);
  endproperty
  a_ret: assert property (p_ret) else $error("return failed");
  property p_discard;
    !wait_reg && skip_o |=> $stable(acc_o) && $stable(carry_o) && $stable(sp_o);
  endproperty
  a_discard: assert property (p_discard) else $error("skipped op acted");
  property p_glitch;
    wait_reg && fix_reg && op == 8'h3C |=> s_glitch;
  endproperty
  a_glitch: assert property (p_glitch) else $error("latch copy wrong");
endmodule
bind nbd_core nbd_core_monitor u_mon (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .rom_data_i(rom_data_i), .ram_nibble_i(ram_nibble_i), .pc_o(pc_o), .acc_o(acc_o),
  .carry_o(carry_o), .skip_o(skip_o), .sp_o(sp_o), .latch_o(latch_o));
`default_nettype wire

// >>> sim/nbd_core_bench.sv
// self-checking bench for the alu/branch decoder with a reference model
`timescale 1ns/1ns
`default_nettype none
module nbd_core_bench
  import nbd_pkg::*;
  ;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] rom_data_i = 8'h00;
  logic [3:0] ram_nibble_i = 4'h0;
  logic [NBD_PC_W-1:0] rom_addr_o;
  logic [NBD_PC_W-1:0] pc_o;
  logic [3:0] acc_o;
  logic carry_o;
  logic skip_o;
  logic [NBD_SP_W-1:0] sp_o;
  logic [7:0] latch_o;
  logic ext_valid_o;
  nbd_ext_op_t ext_op_o;
  integer seed = 14;
  integer bad_count = 0;
  integer num_checks = 0;
  integer r;
  logic [7:0] b;
  logic [3:0] m_acc = 4'h0;
  logic m_c = 1'b0;
  logic m_sk = 1'b0;
  logic [1:0] m_sp = 2'h0;
  logic [10:0] m_pc = 11'h000;
  logic [10:0] m_st [4] = '{default: 11'h000};
  logic [7:0] pick [16] = '{8'h30, 8'h31, 8'h4A, 8'h50, 8'h10, 8'h00, 8'h40, 8'h44,
    8'h32, 8'h22, 8'h02, 8'h33, 8'hFF, 8'h60, 8'h48, 8'h80};
  always #50 clk_sys_i = ~clk_sys_i;
  nbd_core dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .rom_data_i(rom_data_i),
    .ram_nibble_i(ram_nibble_i), .rom_addr_o(rom_addr_o), .pc_o(pc_o), .acc_o(acc_o),
    .carry_o(carry_o), .skip_o(skip_o), .sp_o(sp_o), .latch_o(latch_o),
    .ext_valid_o(ext_valid_o), .ext_op_o(ext_op_o));
  // reference nibble adder: bit 4 is the carry out
  function automatic logic [4:0] ref_add(input logic [3:0] a, input logic [3:0] b,
    input logic c);
    ref_add = {1'b0, a} + {1'b0, b} + {4'h0, c};
  endfunction
  task chk(input string n, input logic [10:0] e, input logic [10:0] g);
    num_checks++;
    if (e !== g)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // one instruction: bytes go out at falling edges, the model follows, then compare
  task op(input logic [7:0] op1, input logic [7:0] op2);
    logic [4:0] s;
    logic two;
    logic live;
    logic [10:0] p;
    logic ev;
    logic [18:0] eop;
    two = op1 == 8'h33 || op1 == 8'h23 || op1[7:4] == 4'h6;
    live = !m_sk;
    p = m_pc;
    rom_data_i = op1;
    ram_nibble_i = 4'($random(seed));
    @(negedge clk_sys_i);
    if (two || (live && op1 == 8'hFF))
    begin
      if (live && op1 == 8'hFF)
        chk("table address", {p[10:8], m_acc, ram_nibble_i}, rom_addr_o);
      rom_data_i = op2;
      @(negedge clk_sys_i);
    end
    m_pc = p + (two ? 11'h2 : 11'h1);
    m_sk = 1'b0;
    ev = 1'b0;
    s = 5'(m_acc);
    // ram is held over both bytes, so the sampling cycle never matters
    if (live)
      casez (op1)
        8'h30, 8'h10:
        begin
          s = ref_add(op1[5] ? m_acc : ~m_acc, ram_nibble_i, m_c);
          m_c = s[4];
          m_sk = s[4];
        end
        8'h31: s = ref_add(m_acc, ram_nibble_i, 1'b0);
        8'h4A: s = ref_add(m_acc, 4'hA, 1'b0);
        8'h5?:
        begin
          s = ref_add(m_acc, op1[3:0], 1'b0);
          m_sk = s[4] && op1[3:0] != 4'h0;
        end
        8'h00: s = 5'h00;
        8'h40: s = 5'(~m_acc);
        8'h32, 8'h22: m_c = !op1[4];
        8'h02: s = 5'(m_acc ^ ram_nibble_i);
        8'h33:
          if (op2 == 8'h1A) s = 5'(m_acc | ram_nibble_i);
          else if (op2 != 8'h3C) ev = 1'b1;
        8'hFF: m_pc = {p[10:8], op2};
        8'h6?:
        begin
          if (op1[3])
          begin
            m_st[m_sp] = m_pc;
            m_sp++;
          end
          m_pc = {op1[2:0], op2};
        end
        8'h48, 8'h49:
        begin
          m_sp--;
          m_pc = m_st[m_sp];
          m_sk = op1[0];
        end
        default:
          if (op1[7] && p[10:7] == 4'h1) m_pc = {p[10:7], op1[6:0]};
          else if (op1[7:6] == 2'h3) m_pc = {p[10:6], op1[5:0]};
          else if (op1[7])
          begin
            m_st[m_sp] = m_pc;
            m_sp++;
            m_pc = {5'h02, op1[5:0]};
          end
          else if (op1 != 8'h44) ev = 1'b1;
      endcase
    m_acc = s[3:0];
    eop = {two, op1, two ? op2 : 8'h00};
    chk("acc", 11'(m_acc), 11'(acc_o));
    chk("carry", 11'(m_c), 11'(carry_o));
    chk("skip", 11'(m_sk), 11'(skip_o));
    chk("pc", m_pc, pc_o);
    chk("sp", 11'(m_sp), 11'(sp_o));
    chk("rom address", m_pc, rom_addr_o);
    chk("ext valid", 11'(ev), 11'(ext_valid_o));
    if (ev)
    begin
      chk("ext op high", eop[18:8], ext_op_o[18:8]);
      chk("ext op low", 11'(eop[7:0]), 11'(ext_op_o[7:0]));
    end
    if (live && op1 == 8'h33 && op2 == 8'h3C)
    begin
      chk("latch early", 11'h03C, 11'(latch_o));
      @(negedge clk_sys_i);
      chk("latch", 11'({m_acc, ram_nibble_i}), 11'(latch_o));
      chk("pc held", m_pc, pc_o);
    end
  endtask
  task tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    op(8'h00, 8'h00);
    op(8'h5F, 8'h00);
    op(8'h50, 8'h00);
    op(8'h22, 8'h00);
    op(8'h30, 8'h00);
    op(8'h61, 8'h23);
    op(8'h60, 8'hA0);
    op(8'h68, 8'h40);
    op(8'h49, 8'h00);
    op(8'h33, 8'h1A);
    op(8'h33, 8'h1A);
    op(8'h33, 8'h3C);
    op(8'h85, 8'h00);
    op(8'h60, 8'h10);
    op(8'hC7, 8'h00);
    op(8'h95, 8'h00);
    op(8'h48, 8'h00);
    op(8'h32, 8'h00);
    op(8'h44, 8'h00);
    op(8'h4A, 8'h00);
    op(8'h10, 8'h00);
    op(8'h40, 8'h00);
    op(8'h02, 8'h00);
    op(8'h31, 8'h00);
    op(8'hFF, 8'h37);
    op(8'h21, 8'h00);
    op(8'h23, 8'h45);
    op(8'h33, 8'h2C);
    $display("corner cases done");
    // random stream over the decoded set except 49 and 23, operands drawn at random; 33 only takes 1A or 3C
    repeat (600)
    begin
      r = $random(seed);
      b = pick[r[3:0]];
      if (b == 8'h50 || b == 8'h60) b[3:0] = r[7:4];
      if (b == 8'h80) b[6:0] = r[10:4];
      op(b, b == 8'h33 ? (r[11] ? 8'h1A : 8'h3C) : r[19:12]);
    end
    $display("random stream done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
